/* verilog/rpsi_pkg.sv */
// Constants and types for the receiver status-indicator block
package rpsi_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] THR_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] EVT_OFF = 8'h0c;

  // Control register fields
  localparam int CTRL_RST_BIT = 0;
  localparam int CTRL_SER_BIT = 1;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int CTRL_XAUI_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Run-length threshold register
  localparam int THR_W = 8;
  localparam logic [7:0] THR_RESET = 8'h05;

  // Live status register fields
  localparam int STAT_ALIGN_BIT = 0;
  localparam int STAT_SYNC_LSB = 1;
  localparam int STAT_EMPTY_BIT = 3;
  localparam int STAT_FULL_BIT = 4;
  localparam int STAT_LIVE_W = 5;
  localparam int STAT_PEND_BIT = 8;

  // Sticky event register fields
  localparam int EVT_RLV_BIT = 0;
  localparam int EVT_INS_BIT = 1;
  localparam int EVT_DEL_BIT = 2;
  localparam int EVT_EMPTY_BIT = 3;
  localparam int EVT_FULL_BIT = 4;
  localparam int EVT_W = 5;

  // ****************************************
  // Timing and codes
  // ****************************************
  localparam logic [1:0] HOLD_PLAIN = 2'h2;
  localparam logic [1:0] HOLD_SER = 2'h3;
  localparam logic [2:0] DSK_ACQ_FIRST = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ALIGN_AUTO, ALIGN_MANUAL, ALIGN_BITSLIP} rpsi_align_type;

endpackage : rpsi_pkg

/* verilog/rpsi_status.sv */
// Receiver status indicators with an AXI4-Lite register slave
`timescale 1ns/100ps

// How it works
// R1 - Pulse run-length flag when identical-bit run exceeds programmed threshold.
// R2 - Hold run-length pulse two cycles, three with byte serializer.
// R3 - Automatic mode: word sync high while stay-synchronized conditions hold.
// R4 - Manual mode: word sync high one cycle with pattern MSByte.
// R5 - Bit-slip mode: no word sync indication.
// R6 - Word sync one bit for 8/10 width, two for 16/20.
// R7 - Lanes-deskewed high in any aligned-acquired deskew state.
// R8 - Lanes-deskewed low in loss or align-detect deskew states.
// R9 - Lanes-deskewed only offered in XAUI mode.
// R10 - Skip-removed flag marks a deleted rate-match byte.
// R11 - Skip-added flag marks an inserted rate-match byte.
// R12 - Empty flag high when FIFO empty, held two or three cycles.
// R13 - Full flag high when FIFO full, held two or three cycles.
// R14 - User logic asserts digital reset to clear empty or full.
// R15 - Decoder status one bit for 8-bit width, two for 16-bit.
// R16 - Flags live on recovered clock and clear under digital reset.
module rpsi_status #(
  parameter int DW = 20
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rxClk,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [DW-1:0] rxWord,
  input wire logic [1:0] syncOkIn,
  input wire logic [1:0] patternHitIn,
  input wire logic [2:0] deskewStateIn,
  input wire logic rmDeletedIn,
  input wire logic rmInsertedIn,
  input wire logic rmEmptyIn,
  input wire logic rmFullIn,
  input wire logic [1:0] decCtrlIn,
  input wire logic [1:0] decDispErrIn,
  input wire logic [1:0] decErrIn,
  input wire logic [1:0] decRunDispIn,
  output logic runLenViol,
  output logic [1:0] wordSync,
  output logic lanesDeskewed,
  output logic skipRemoved,
  output logic skipAdded,
  output logic rmFifoEmpty,
  output logic rmFifoFull,
  output logic [1:0] decCtrl,
  output logic [1:0] decDispErr,
  output logic [1:0] decErr,
  output logic [1:0] decRunDisp
);

  localparam int CFG_W = rpsi_pkg::THR_W + 5;

  // ****************************************
  // Register bus side (mclk)
  // ****************************************
  logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [rpsi_pkg::CTRL_W-1:0] ctrl_reg;
  logic [rpsi_pkg::THR_W-1:0] thr_reg;
  logic [rpsi_pkg::EVT_W-1:0] events_reg;
  logic [rpsi_pkg::EVT_W-1:0] evtS1_reg, evtS2_reg, evtS3_reg;
  logic [rpsi_pkg::STAT_LIVE_W-1:0] liveS1_reg, liveS2_reg;
  logic hardReq_reg, digReq_reg, cfgDirty_reg, reqTgl_reg, ackS1_reg, ackS2_reg;
  logic [CFG_W-1:0] cfgSnap_reg;

  // Link side (rxClk)
  logic hardS1_reg, hardS2_reg, digS1_reg, digS2_reg;
  logic reqS1_reg, reqS2_reg, ackTgl_reg;
  logic cfgSer_reg, cfgWide_reg, cfgXaui_reg;
  logic [1:0] cfgMode_reg;
  logic [rpsi_pkg::THR_W-1:0] cfgThr_reg;
  logic [rpsi_pkg::THR_W-1:0] runCnt_reg;
  logic lastBit_reg;
  logic [1:0] holdCnt_reg, hitPrev_reg;
  logic rlv_reg, align_reg, del_reg, ins_reg, empty_reg, full_reg;
  logic [1:0] sync_reg, decCtrl_reg, decDisp_reg, decErr_reg, decRun_reg;
  logic [rpsi_pkg::EVT_W-1:0] flagsPrev_reg, evtTgl_reg;

  // Bus decode and byte-lane masking
  wire wrGo = awvalid && wvalid && !awready_reg && !bvalid_reg;
  wire wrFire = awvalid && awready_reg;
  wire rdGo = arvalid && !arready_reg && !rvalid_reg;
  wire rdFire = arvalid && arready_reg;
  wire wrCtrl = awaddr[7:2] == rpsi_pkg::CTRL_OFF[7:2];
  wire wrThr = awaddr[7:2] == rpsi_pkg::THR_OFF[7:2];
  wire wrEvt = awaddr[7:2] == rpsi_pkg::EVT_OFF[7:2];
  wire wrStat = awaddr[7:2] == rpsi_pkg::STAT_OFF[7:2];
  wire wrHit = wrCtrl || wrThr || wrEvt || wrStat;
  wire [31:0] laneMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] ctrlWord = {{(32 - rpsi_pkg::CTRL_W){1'b0}}, ctrl_reg};
  wire [31:0] thrWord = {{(32 - rpsi_pkg::THR_W){1'b0}}, thr_reg};
  wire [31:0] ctrlMerged = (ctrlWord & ~laneMask) | (wdata & laneMask);
  wire [31:0] thrMerged = (thrWord & ~laneMask) | (wdata & laneMask);
  wire [rpsi_pkg::EVT_W-1:0] evtClr =
    (wrFire && wrEvt) ? (wdata[rpsi_pkg::EVT_W-1:0] & laneMask[rpsi_pkg::EVT_W-1:0]) : '0;
  wire [rpsi_pkg::EVT_W-1:0] evtRise = evtS2_reg ^ evtS3_reg;
  wire cfgIdle = reqTgl_reg == ackS2_reg;
  wire [CFG_W-1:0] cfgShadow = {ctrl_reg[rpsi_pkg::CTRL_MODE_LSB +: 2],
    ctrl_reg[rpsi_pkg::CTRL_XAUI_BIT], ctrl_reg[rpsi_pkg::CTRL_WIDE_BIT],
    ctrl_reg[rpsi_pkg::CTRL_SER_BIT], thr_reg};

  // Read data selection; unmapped words read zero with an error
  wire rdCtrl = araddr[7:2] == rpsi_pkg::CTRL_OFF[7:2];
  wire rdThr = araddr[7:2] == rpsi_pkg::THR_OFF[7:2];
  wire rdStat = araddr[7:2] == rpsi_pkg::STAT_OFF[7:2];
  wire rdEvt = araddr[7:2] == rpsi_pkg::EVT_OFF[7:2];
  wire [31:0] statWord = {{(31 - rpsi_pkg::STAT_PEND_BIT){1'b0}}, !cfgIdle,
    {(rpsi_pkg::STAT_PEND_BIT - rpsi_pkg::STAT_LIVE_W){1'b0}}, liveS2_reg};
  wire [31:0] rdMux = rdCtrl ? ctrlWord : rdThr ? thrWord : rdStat ? statWord :
    rdEvt ? {{(32 - rpsi_pkg::EVT_W){1'b0}}, events_reg} : 32'h0000_0000;
  wire rdHit = rdCtrl || rdThr || rdStat || rdEvt;

  // Write channel: address and data taken together, then the response
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= rpsi_pkg::RESP_OKAY;
    end else begin
      awready_reg <= wrGo;
      if (wrFire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wrHit ? rpsi_pkg::RESP_OKAY : rpsi_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= rpsi_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      arready_reg <= rdGo;
      if (rdFire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdMux;
        rresp_reg <= rdHit ? rpsi_pkg::RESP_OKAY : rpsi_pkg::RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Control and threshold; any change is marked for transfer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_reg <= rpsi_pkg::CTRL_RESET;
      thr_reg <= rpsi_pkg::THR_RESET;
      cfgDirty_reg <= 1'b1;
    end else begin
      if (wrFire && wrCtrl) begin
        ctrl_reg <= ctrlMerged[rpsi_pkg::CTRL_W-1:0];
      end
      if (wrFire && wrThr) begin
        thr_reg <= thrMerged[rpsi_pkg::THR_W-1:0];
      end
      if (wrFire && (wrCtrl || wrThr)) begin
        cfgDirty_reg <= 1'b1;
      end else if (cfgIdle) begin
        cfgDirty_reg <= 1'b0;
      end
    end
  end

  // Config word handshake: snapshot held still until acknowledged
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reqTgl_reg <= 1'b0;
      cfgSnap_reg <= '0;
    end else if (cfgDirty_reg && cfgIdle) begin
      reqTgl_reg <= !reqTgl_reg;
      cfgSnap_reg <= cfgShadow;
    end
  end

  // Reset levels toward the link; constants only under reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hardReq_reg <= 1'b1;
      digReq_reg <= 1'b1;
    end else begin
      hardReq_reg <= 1'b0;
      digReq_reg <= ctrl_reg[rpsi_pkg::CTRL_RST_BIT];
    end
  end

  // Synchronisers into mclk for acknowledge and live levels
  always_ff @(posedge mclk) begin
    ackS1_reg <= ackTgl_reg;
    ackS2_reg <= ackS1_reg;
    liveS1_reg <= {full_reg, empty_reg, sync_reg, align_reg};
    liveS2_reg <= liveS1_reg;
  end

  // Event stages; third only feeds edge detect
  // Zeroed in reset, else an unknown or stale toggle sets a false event
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      evtS1_reg <= '0;
      evtS2_reg <= '0;
      evtS3_reg <= '0;
    end else begin
      evtS1_reg <= evtTgl_reg;
      evtS2_reg <= evtS1_reg;
      evtS3_reg <= evtS2_reg;
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      events_reg <= '0;
    end else begin
      events_reg <= (events_reg & ~evtClr) | evtRise;
    end
  end

  // ****************************************
  // Link side (recovered clock)
  // ****************************************
  wire linkHard = hardS2_reg;
  // R16 digital reset clears flags
  wire linkRst = hardS2_reg || digS2_reg;
  wire [1:0] holdLen = cfgSer_reg ? rpsi_pkg::HOLD_SER : rpsi_pkg::HOLD_PLAIN;
  wire [1:0] widthMask = {cfgWide_reg, 1'b1};
  wire [1:0] hitRise = patternHitIn & ~hitPrev_reg;
  wire alignNext = cfgXaui_reg && (deskewStateIn >= rpsi_pkg::DSK_ACQ_FIRST);
  wire [rpsi_pkg::EVT_W-1:0] flagsNow = {full_reg, empty_reg, del_reg, ins_reg, rlv_reg};

  // Reset and config handshake synchronisers
  always_ff @(posedge rxClk) begin
    hardS1_reg <= hardReq_reg;
    hardS2_reg <= hardS1_reg;
    digS1_reg <= digReq_reg;
    digS2_reg <= digS1_reg;
    reqS1_reg <= reqTgl_reg;
    reqS2_reg <= reqS1_reg;
  end

  // Capture config once a new request arrives; survives digital reset
  always_ff @(posedge rxClk) begin
    if (linkHard) begin
      ackTgl_reg <= 1'b0;
      {cfgMode_reg, cfgXaui_reg, cfgWide_reg, cfgSer_reg} <= 5'h00;
      cfgThr_reg <= rpsi_pkg::THR_RESET;
    end else if (reqS2_reg != ackTgl_reg) begin
      ackTgl_reg <= reqS2_reg;
      {cfgMode_reg, cfgXaui_reg, cfgWide_reg, cfgSer_reg, cfgThr_reg} <= cfgSnap_reg;
    end
  end

  // R1 run-length walk, LSB first, carried across words
  logic [rpsi_pkg::THR_W-1:0] runWalk;
  logic bitWalk;
  logic violWalk;
  always_comb begin
    runWalk = runCnt_reg;
    bitWalk = lastBit_reg;
    violWalk = 1'b0;
    for (int i = 0; i < DW; i++) begin
      if (i < DW / 2 || cfgWide_reg) begin
        if (rxWord[i] == bitWalk) begin
          if (runWalk != '1) begin
            runWalk = runWalk + 1'b1;
          end
        end else begin
          runWalk = rpsi_pkg::THR_W'(1);
          bitWalk = rxWord[i];
        end
        if (runWalk > cfgThr_reg) begin
          violWalk = 1'b1;
        end
      end
    end
  end

  // R2 pulse stretched to the hold length
  always_ff @(posedge rxClk) begin
    if (linkRst) begin
      runCnt_reg <= '0;
      lastBit_reg <= 1'b0;
      holdCnt_reg <= 2'h0;
      rlv_reg <= 1'b0;
    end else begin
      runCnt_reg <= runWalk;
      lastBit_reg <= bitWalk;
      if (violWalk) begin
        holdCnt_reg <= holdLen - 2'h1;
        rlv_reg <= 1'b1;
      end else if (holdCnt_reg != 2'h0) begin
        holdCnt_reg <= holdCnt_reg - 2'h1;
        rlv_reg <= 1'b1;
      end else begin
        rlv_reg <= 1'b0;
      end
    end
  end

  // R3 R4 R5 R6 word sync per alignment mode
  logic [1:0] syncNext;
  always_comb begin
    case (rpsi_pkg::rpsi_align_type'(cfgMode_reg))
      rpsi_pkg::ALIGN_AUTO: syncNext = syncOkIn & widthMask;
      rpsi_pkg::ALIGN_MANUAL: syncNext = hitRise & widthMask;
      default: syncNext = 2'h0;
    endcase
  end

  // R7 R8 R9 deskew, rate match and decoder flags
  always_ff @(posedge rxClk) begin
    if (linkRst) begin
      hitPrev_reg <= 2'h0;
      sync_reg <= 2'h0;
      align_reg <= 1'b0;
      del_reg <= 1'b0;
      ins_reg <= 1'b0;
      decCtrl_reg <= 2'h0;
      decDisp_reg <= 2'h0;
      decErr_reg <= 2'h0;
      decRun_reg <= 2'h0;
    end else begin
      hitPrev_reg <= patternHitIn;
      sync_reg <= syncNext;
      align_reg <= alignNext;
      // R10 R11 one flag per skip event
      del_reg <= rmDeletedIn;
      ins_reg <= rmInsertedIn;
      // R15 upper lane unused when narrow
      decCtrl_reg <= decCtrlIn & widthMask;
      decDisp_reg <= decDispErrIn & widthMask;
      decErr_reg <= decErrIn & widthMask;
      decRun_reg <= decRunDispIn & widthMask;
    end
  end

  // R12 R13 empty/full stick until digital reset, so any hold is met
  // R14 only a reset, digital or hard, clears them
  always_ff @(posedge rxClk) begin
    if (linkRst) begin
      empty_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      empty_reg <= empty_reg || rmEmptyIn;
      full_reg <= full_reg || rmFullIn;
    end
  end

  // Event toggles; cleared only by hard reset to avoid false edges
  always_ff @(posedge rxClk) begin
    if (linkHard) begin
      flagsPrev_reg <= '0;
      evtTgl_reg <= '0;
    end else begin
      flagsPrev_reg <= flagsNow;
      evtTgl_reg <= evtTgl_reg ^ (flagsNow & ~flagsPrev_reg);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign awready = awready_reg;
  assign wready = awready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign runLenViol = rlv_reg;
  assign wordSync = sync_reg;
  assign lanesDeskewed = align_reg;
  assign skipRemoved = del_reg;
  assign skipAdded = ins_reg;
  assign rmFifoEmpty = empty_reg;
  assign rmFifoFull = full_reg;
  assign decCtrl = decCtrl_reg;
  assign decDispErr = decDisp_reg;
  assign decErr = decErr_reg;
  assign decRunDisp = decRun_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence seqHold2;
    rlv_reg [*2];
  endsequence
  sequence seqHold3;
    rlv_reg [*3];
  endsequence

  AST_RLV_SEEN: assert property (@(posedge rxClk) disable iff (linkRst) // R1
    violWalk |=> rlv_reg) else $error("run-length flag missed");
  AST_RLV_HOLD2: assert property (@(posedge rxClk) disable iff (linkRst) // R2
    (violWalk && !cfgSer_reg) |=> seqHold2) else $error("run-length pulse short");
  AST_RLV_HOLD3: assert property (@(posedge rxClk) disable iff (linkRst) // R2
    (violWalk && cfgSer_reg) |=> seqHold3) else $error("run-length pulse short");
  AST_SYNC_AUTO: assert property (@(posedge rxClk) disable iff (linkRst) // R3
    (cfgMode_reg == rpsi_pkg::ALIGN_AUTO && syncOkIn[0]) |=> sync_reg[0])
    else $error("auto sync not shown");
  AST_SYNC_ONE: assert property (@(posedge rxClk) disable iff (linkRst) // R4
    (cfgMode_reg == rpsi_pkg::ALIGN_MANUAL && hitRise[0]) |=> sync_reg[0] ##1 !sync_reg[0])
    else $error("manual sync not one cycle");
  AST_SYNC_SLIP: assert property (@(posedge rxClk) disable iff (linkRst) // R5
    (cfgMode_reg == rpsi_pkg::ALIGN_BITSLIP) |=> sync_reg == 2'h0)
    else $error("sync shown in bit-slip");
  AST_SYNC_NARROW: assert property (@(posedge rxClk) disable iff (linkRst) // R6
    !cfgWide_reg |=> !sync_reg[1]) else $error("upper sync bit in narrow width");
  AST_ALIGN_HIGH: assert property (@(posedge rxClk) disable iff (linkRst) // R7
    (cfgXaui_reg && deskewStateIn >= rpsi_pkg::DSK_ACQ_FIRST) |=> align_reg)
    else $error("deskew flag low when acquired");
  AST_ALIGN_LOW: assert property (@(posedge rxClk) disable iff (linkRst) // R8
    (deskewStateIn < rpsi_pkg::DSK_ACQ_FIRST) |=> !align_reg)
    else $error("deskew flag high when not acquired");
  AST_ALIGN_XAUI: assert property (@(posedge rxClk) disable iff (linkRst) // R9
    !cfgXaui_reg |=> !align_reg) else $error("deskew flag outside XAUI");
  AST_SKIP_DEL: assert property (@(posedge rxClk) disable iff (linkRst) // R10
    rmDeletedIn |=> skipRemoved) else $error("deletion not flagged");
  AST_SKIP_INS: assert property (@(posedge rxClk) disable iff (linkRst) // R11
    rmInsertedIn |=> skipAdded) else $error("insertion not flagged");
  AST_EMPTY_HOLD: assert property (@(posedge rxClk) disable iff (linkRst) // R12
    rmEmptyIn |=> empty_reg [*3]) else $error("empty flag not held");
  AST_FULL_HOLD: assert property (@(posedge rxClk) disable iff (linkRst) // R13
    rmFullIn |=> full_reg [*3]) else $error("full flag not held");
  AST_DEC_NARROW: assert property (@(posedge rxClk) disable iff (linkRst) // R15
    !cfgWide_reg |=> (decErr_reg[1] == 1'b0 && decCtrl_reg[1] == 1'b0))
    else $error("upper decoder bit in narrow width");
  AST_FLAG_CLEAR: assert property (@(posedge rxClk) disable iff (1'b0) // R16
    linkRst |=> (flagsNow == '0 && sync_reg == 2'h0 && !align_reg))
    else $error("flags not cleared by reset");
  AST_WR_RESP: assert property (@(posedge mclk) disable iff (!rst_b)
    wrFire |=> bvalid_reg) else $error("write response missing");

endmodule : rpsi_status

/* tb/rpsi_fabric_model.sv */
// Fabric-side consumer of the receiver status flags
`timescale 1ns/100ps
module rpsi_fabric_model (
  input wire logic rxClk,
  input wire logic rmFifoEmpty,
  input wire logic rmFifoFull,
  output logic clearReq
);
  // ****************************************
  // Reset request
  // ****************************************
  // ask for reset
  // A stuck FIFO flag only clears by reset, digital or hard, so request a digital one
  always_ff @(posedge rxClk) begin
    clearReq <= rmFifoEmpty | rmFifoFull;
  end
endmodule : rpsi_fabric_model

/* tb/rpsi_status_test.sv */
// Self-checking testbench for the receiver status-indicator block
`timescale 1ns/100ps
module rpsi_status_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic mclk = 0, rxClk = 0, rst_b = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, clearReq;
  logic [1:0] bresp, rresp, wordSync, decCtrl, decDispErr, decErr, decRunDisp;
  logic [31:0] rdata;
  logic [19:0] rxWord = 20'h55555;
  logic [1:0] syncOkIn = 0, patternHitIn = 0, decCtrlIn = 0, decDispErrIn = 0;
  logic [1:0] decErrIn = 0, decRunDispIn = 0;
  logic [2:0] deskewStateIn = 0;
  logic rmDeletedIn = 0, rmInsertedIn = 0, rmEmptyIn = 0, rmFullIn = 0;
  logic runLenViol, lanesDeskewed, skipRemoved, skipAdded, rmFifoEmpty, rmFifoFull;
  int n_mismatch = 0, num_checks = 0;

  rpsi_status #(.DW(20)) dut (.mclk(mclk), .rst_b(rst_b), .rxClk(rxClk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxWord(rxWord), .syncOkIn(syncOkIn), .patternHitIn(patternHitIn),
    .deskewStateIn(deskewStateIn), .rmDeletedIn(rmDeletedIn), .rmInsertedIn(rmInsertedIn),
    .rmEmptyIn(rmEmptyIn), .rmFullIn(rmFullIn), .decCtrlIn(decCtrlIn),
    .decDispErrIn(decDispErrIn), .decErrIn(decErrIn), .decRunDispIn(decRunDispIn),
    .runLenViol(runLenViol), .wordSync(wordSync), .lanesDeskewed(lanesDeskewed),
    .skipRemoved(skipRemoved), .skipAdded(skipAdded), .rmFifoEmpty(rmFifoEmpty),
    .rmFifoFull(rmFifoFull), .decCtrl(decCtrl), .decDispErr(decDispErr), .decErr(decErr),
    .decRunDisp(decRunDisp));

  rpsi_fabric_model fab (.rxClk(rxClk), .rmFifoEmpty(rmFifoEmpty), .rmFifoFull(rmFifoFull),
    .clearReq(clearReq));

  // Clocks with unrelated periods
  always #12.5 mclk = ~mclk;
  always #7.5 rxClk = ~rxClk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task results;
    $display("Mismatches %0d, checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task lk(input int n);
    repeat (n) @(posedge rxClk);
  endtask : lk

  // Write: address and data offered together, held until taken
  task axW(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (awready) begin
        awvalid <= 0;
        wvalid <= 0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
    end
    if (!done) begin
      chk(0, "write timeout");
      results();
    end
  endtask : axW

  task axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 0;
        done = 1;
      end
    end
    if (!done) begin
      chk(0, "read timeout");
      results();
    end
  endtask : axR

  // Config crosses to the link clock, so give it time to land
  task cfg(input logic [31:0] v);
    logic [1:0] r;
    axW(rpsi_pkg::CTRL_OFF, v, r);
    lk(12);
  endtask : cfg

  // Count cycles a chosen one-bit flag is high
  task cnt(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge rxClk);
      case (sel)
        0: c += (runLenViol === 1'b1);
        1: c += (wordSync[0] === 1'b1);
        2: c += (skipRemoved === 1'b1);
        default: c += (skipAdded === 1'b1);
      endcase
    end
  endtask : cnt

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, write and readback, unmapped place
  task tRegs;
    logic [31:0] d;
    logic [1:0] r;
    axR(rpsi_pkg::CTRL_OFF, d, r);
    chk(d[5:0] === rpsi_pkg::CTRL_RESET && r === rpsi_pkg::RESP_OKAY, "ctrl reset");
    axR(rpsi_pkg::THR_OFF, d, r);
    chk(d[7:0] === rpsi_pkg::THR_RESET, "thr reset");
    axR(8'h10, d, r);
    chk(r === rpsi_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    axW(8'h10, 32'h1, r);
    chk(r === rpsi_pkg::RESP_SLVERR, "unmapped write");
    axW(rpsi_pkg::THR_OFF, 32'h7, r);
    axR(rpsi_pkg::THR_OFF, d, r);
    chk(d[7:0] === 8'h07, "thr write");
    axW(rpsi_pkg::THR_OFF, {24'h0, rpsi_pkg::THR_RESET}, r);
  endtask : tRegs

  // Run of exactly five zeros stays quiet, six zeros pulses for the hold
  task tRun(input bit ser, input int h);
    int c;
    cfg(32'(ser) << rpsi_pkg::CTRL_SER_BIT);
    for (int i = 0; i < 2; i++) begin
      @(posedge rxClk) rxWord <= {10'h155, i ? 10'h381 : 10'h341};
      @(posedge rxClk) rxWord <= 20'h55555;
      cnt(0, 12, c);
      chk(c == (i ? h : 0), "run-length pulse");
    end
  endtask : tRun

  // Word sync in auto at both widths, wide bit-slip and narrow manual modes
  task tSync;
    int c;
    syncOkIn <= 2'b11;
    cfg(32'h0);
    chk(wordSync === 2'b01, "auto narrow");
    cfg(32'h1 << rpsi_pkg::CTRL_WIDE_BIT);
    chk(wordSync === 2'b11, "auto wide");
    syncOkIn <= 2'b00;
    lk(3);
    chk(wordSync === 2'b00, "auto lost");
    syncOkIn <= 2'b11;
    cfg(32'h24);
    chk(wordSync === 2'b00, "bitslip");
    cfg(32'h34);
    chk(wordSync === 2'b00, "no-sync mode");
    cfg(32'h10);
    @(posedge rxClk) patternHitIn <= 2'b01;
    cnt(1, 10, c);
    chk(c == 1, "manual one cycle");
    patternHitIn <= 2'b00;
    syncOkIn <= 2'b00;
  endtask : tSync

  // Every deskew state, with and without XAUI
  task tDeskew;
    for (int x = 0; x < 2; x++) begin
      cfg(32'(x) << rpsi_pkg::CTRL_XAUI_BIT);
      for (int s = 0; s < 8; s++) begin
        @(posedge rxClk) deskewStateIn <= 3'(s);
        lk(3);
        chk(lanesDeskewed === 1'(x && s >= rpsi_pkg::DSK_ACQ_FIRST), "deskew");
      end
    end
  endtask : tDeskew

  // One delete and one insert event
  task tRate;
    int c;
    cfg(32'h0);
    @(posedge rxClk) rmDeletedIn <= 1;
    @(posedge rxClk) rmDeletedIn <= 0;
    cnt(2, 6, c);
    chk(c == 1, "skip removed");
    @(posedge rxClk) rmInsertedIn <= 1;
    @(posedge rxClk) rmInsertedIn <= 0;
    cnt(3, 6, c);
    chk(c == 1, "skip added");
  endtask : tRate

  // Empty then full: flag outlives input until digital reset
  task tFifo;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 2; k++) begin
      @(posedge rxClk) {rmFullIn, rmEmptyIn} <= k ? 2'b10 : 2'b01;
      @(posedge rxClk) {rmFullIn, rmEmptyIn} <= 2'b00;
      for (n = 0; n < 20 && clearReq !== 1'b1; n++) @(posedge rxClk);
      chk(clearReq === 1'b1, "fabric clear request");
      lk(4);
      chk((k ? rmFifoFull : rmFifoEmpty) === 1'b1, "fifo flag hold");
      axR(rpsi_pkg::STAT_OFF, d, r);
      n = k ? rpsi_pkg::STAT_FULL_BIT : rpsi_pkg::STAT_EMPTY_BIT;
      chk(d === (32'h1 << n), "stat level");
      cfg(32'h1);
      cfg(32'h0);
      chk({rmFifoFull, rmFifoEmpty} === 2'b00, "fifo flag cleared");
    end
    axR(rpsi_pkg::EVT_OFF, d, r);
    chk(d === 32'((1 << rpsi_pkg::EVT_W) - 1), "sticky events");
    axW(rpsi_pkg::EVT_OFF, 32'((1 << rpsi_pkg::EVT_W) - 1), r);
    axR(rpsi_pkg::EVT_OFF, d, r);
    chk(d === 32'h0 && r === rpsi_pkg::RESP_OKAY, "events cleared");
  endtask : tFifo

  // Decoder status width and a register reset mid-run
  task tDec;
    {decCtrlIn, decDispErrIn, decErrIn, decRunDispIn} <= 8'hff;
    cfg(32'h0);
    chk({decCtrl, decDispErr, decErr, decRunDisp} === 8'h55, "dec narrow");
    cfg(32'h4);
    chk({decCtrl, decDispErr, decErr, decRunDisp} === 8'hff, "dec wide");
    @(posedge mclk) rst_b <= 0;
    lk(6);
    chk({decErr, runLenViol, wordSync} === 5'h0, "reset clears");
    @(posedge mclk) rst_b <= 1;
  endtask : tDec

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1;
    lk(8);
    tRegs();
    tRun(0, rpsi_pkg::HOLD_PLAIN);
    tRun(1, rpsi_pkg::HOLD_SER);
    tSync();
    tDeskew();
    tRate();
    tFifo();
    tDec();
    results();
  end
endmodule : rpsi_status_test
